// ==== core/octal_registered_bus_transceiver.sv ====
// octal registered bus transceiver with capture log over apb
// Summary of operation
// - each capture clock rising edge loads its source port into its register
// - capture is never gated by output enable or direction
// - output enable high drives neither port; both registers may still capture
// - enable high and capture clocks static keeps registers and ports undriven
// - enable low drives A when direction low, B when direction high
// - enable low, direction low, B-to-A select low: A follows live B
// - enable low, direction low, B-to-A select high: A shows B-to-A register
// - enable low, direction high, A-to-B select low: B follows live A
// - enable low, direction high, A-to-B select high: B shows A-to-B register
// - the undriven port stays available for capture into its own register (A into A-to-B, B into B-to-A)
// - A and B ports are never driven together
`timescale 1ns/1ps
`default_nettype none
module octal_registered_bus_transceiver #(
  parameter int unsigned LANES = xcvr_pkg::LANES,
  parameter int unsigned LOG_DEPTH = xcvr_pkg::LOG_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [xcvr_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control pins
  input wire logic outputEnableN,
  input wire logic direction,
  input wire logic aToBSourceSelect,
  input wire logic bToASourceSelect,
  input wire logic aToBCaptureClock,
  input wire logic bToACaptureClock,
  // a port lines
  input wire logic [LANES-1:0] aPortLinesIn,
  output logic [LANES-1:0] aPortLinesOut,
  output logic [LANES-1:0] aPortLinesOe,
  // b port lines
  input wire logic [LANES-1:0] bPortLinesIn,
  output logic [LANES-1:0] bPortLinesOut,
  output logic [LANES-1:0] bPortLinesOe,
  // log back-pressure
  output logic logReady
);
  localparam int unsigned CTRL_W = $bits(xcvr_pkg::pinCtrl_s);
  localparam int unsigned ENTRY_W = LANES + 1;
  localparam int unsigned LVL_W = $clog2(LOG_DEPTH) + 1;

  if (LANES != xcvr_pkg::LANES || LOG_DEPTH < 2 || LVL_W > 8) begin : g_chk
    $error("LANES must match the package and LOG_DEPTH must be 2 to 128");
  end

  // synchronised pins
  xcvr_pkg::pinCtrl_s ctrl;
  logic [CTRL_W-1:0] ctrlRaw;
  logic [LANES-1:0] aLive, bLive;

  pin_sync #(.WIDTH(CTRL_W)) u_ctrl_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn({outputEnableN, direction, aToBSourceSelect, bToASourceSelect,
            aToBCaptureClock, bToACaptureClock}),
    .syncOut(ctrlRaw)
  );
  assign ctrl = xcvr_pkg::pinCtrl_s'(ctrlRaw);

  // data lanes share the control pipeline depth, so data meets its clock edge
  pin_sync #(.WIDTH(2 * LANES)) u_data_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn({aPortLinesIn, bPortLinesIn}),
    .syncOut({aLive, bLive})
  );

  // sync flops hold reset zeros for two edges; a zero enable would drive A meanwhile
  logic [1:0] flush_q, flush_d;
  logic driveOk, pinsFresh;

  assign driveOk = flush_q[1];
  // one edge longer, so a clock pin idling high gives no false capture
  assign pinsFresh = (flush_q == 2'h3);

  always_comb begin
    flush_d = pinsFresh ? flush_q : flush_q + 2'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flush_q <= 2'h0;
    end else begin
      flush_q <= flush_d;
    end
  end

  // capture edge detect
  logic abClkPrev_q, abClkPrev_d, baClkPrev_q, baClkPrev_d;
  logic abRise, baRise;

  always_comb begin
    abClkPrev_d = ctrl.aToBCaptureClock;
    baClkPrev_d = ctrl.bToACaptureClock;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      abClkPrev_q <= 1'b0;
      baClkPrev_q <= 1'b0;
    end else begin
      abClkPrev_q <= abClkPrev_d;
      baClkPrev_q <= baClkPrev_d;
    end
  end

  // no enable or direction term here
  assign abRise = ctrl.aToBCaptureClock && !abClkPrev_q && pinsFresh;
  assign baRise = ctrl.bToACaptureClock && !baClkPrev_q && pinsFresh;

  // storage registers
  logic [LANES-1:0] abStore_q, abStore_d, baStore_q, baStore_d;

  always_comb begin
    abStore_d = abRise ? aLive : abStore_q;
    baStore_d = baRise ? bLive : baStore_q;
  end

  // no reset branch on purpose
  always_ff @(posedge ref_clk) begin
    abStore_q <= abStore_d;
    baStore_q <= baStore_d;
  end

  // port drive
  logic aDrive_q, aDrive_d, bDrive_q, bDrive_d;
  logic [LANES-1:0] aOut_q, aOut_d, bOut_q, bOut_d;

  always_comb begin
    aDrive_d = driveOk && !ctrl.outputEnableN && !ctrl.direction;
    bDrive_d = driveOk && !ctrl.outputEnableN && ctrl.direction;
    aOut_d = ctrl.bToASourceSelect ? baStore_q : bLive;
    bOut_d = ctrl.aToBSourceSelect ? abStore_q : aLive;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aDrive_q <= 1'b0;
      bDrive_q <= 1'b0;
      aOut_q <= '0;
      bOut_q <= '0;
    end else begin
      aDrive_q <= aDrive_d;
      bDrive_q <= bDrive_d;
      aOut_q <= aOut_d;
      bOut_q <= bOut_d;
    end
  end

  assign aPortLinesOut = aOut_q;
  assign bPortLinesOut = bOut_q;
  assign aPortLinesOe = {LANES{aDrive_q}};
  assign bPortLinesOe = {LANES{bDrive_q}};

  // capture log
  // one push per cycle; a simultaneous B-to-A capture is counted as dropped
  xcvr_pkg::logEntry_s pushEntry, popEntry;
  logic [1:0] logCtrl_q, logCtrl_d;
  logic [7:0] drops_q, drops_d;
  logic pushValid, popValid, popReady;
  logic [LVL_W-1:0] level;
  logic abLog, baLog;

  assign abLog = abRise && logCtrl_q[xcvr_pkg::LOG_AB_EN_BIT];
  assign baLog = baRise && logCtrl_q[xcvr_pkg::LOG_BA_EN_BIT];

  always_comb begin
    pushValid = abLog || baLog;
    pushEntry.fromB = !abLog;
    pushEntry.data = abLog ? aLive : bLive;
  end

  xcvr_fifo #(.WIDTH(ENTRY_W), .DEPTH(LOG_DEPTH)) u_log_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(pushValid),
    .inReady(logReady),
    .inData(pushEntry),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popEntry),
    .level(level)
  );

  // apb slave, zero wait states
  logic access, wrEn, rdEn, hit;
  logic [xcvr_pkg::APB_ADDR_W-1:0] addr;

  assign access = psel && penable;
  assign addr = paddr;
  assign wrEn = access && pwrite;
  assign rdEn = access && !pwrite;
  assign pready = 1'b1;
  assign popReady = rdEn && (addr == xcvr_pkg::LOG_DATA_OFFSET);

  always_comb begin
    hit = 1'b1;
    prdata = 32'h0000_0000;
    case (addr)
      xcvr_pkg::LOG_CTRL_OFFSET: begin
        prdata[1:0] = logCtrl_q;
      end
      xcvr_pkg::STATUS_OFFSET: begin
        prdata[xcvr_pkg::STAT_AB_LSB +: LANES] = abStore_q;
        prdata[xcvr_pkg::STAT_BA_LSB +: LANES] = baStore_q;
        prdata[xcvr_pkg::STAT_A_DRIVE_BIT] = aDrive_q;
        prdata[xcvr_pkg::STAT_B_DRIVE_BIT] = bDrive_q;
        prdata[xcvr_pkg::STAT_CTRL_LSB +: CTRL_W] = ctrlRaw;
      end
      xcvr_pkg::LOG_DATA_OFFSET: begin
        prdata[LANES-1:0] = popEntry.data;
        prdata[xcvr_pkg::LOGD_FROM_B_BIT] = popEntry.fromB;
        prdata[xcvr_pkg::LOGD_VALID_BIT] = popValid;
      end
      xcvr_pkg::LOG_INFO_OFFSET: begin
        prdata[xcvr_pkg::LOGI_LEVEL_LSB +: LVL_W] = level;
        prdata[xcvr_pkg::LOGI_DROP_LSB +: 8] = drops_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (!rdEn || !hit) begin
      prdata = 32'h0000_0000;
    end
  end

  assign pslverr = access && !hit;

  always_comb begin
    logCtrl_d = logCtrl_q;
    if (wrEn && addr == xcvr_pkg::LOG_CTRL_OFFSET) begin
      logCtrl_d = pwdata[1:0];
    end
    drops_d = drops_q;
    if (wrEn && addr == xcvr_pkg::LOG_INFO_OFFSET) begin
      drops_d = xcvr_pkg::DROP_RESET;
    end
    // a drop in the clearing cycle still counts
    if ((pushValid && !logReady) || (abLog && baLog)) begin
      drops_d = (drops_d == 8'hFF) ? drops_d : drops_d + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      logCtrl_q <= xcvr_pkg::LOG_CTRL_RESET;
      drops_q <= xcvr_pkg::DROP_RESET;
    end else begin
      logCtrl_q <= logCtrl_d;
      drops_q <= drops_d;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  capture_ab_a: assert property (abRise |=> abStore_q == $past(aLive))
    else $error("a-to-b register missed its capture");
  capture_ba_a: assert property (baRise |=> baStore_q == $past(bLive))
    else $error("b-to-a register missed its capture");
  ungated_capture_a: assert property (
    (ctrl.outputEnableN || ctrl.direction) && baRise |=> baStore_q == $past(bLive))
    else $error("capture gated by enable or direction");
  isolation_a: assert property (ctrl.outputEnableN |=> !aDrive_q && !bDrive_q)
    else $error("port driven while output enable high");
  hold_storage_a: assert property (
    ctrl.outputEnableN && !abRise && !baRise |=> $stable(abStore_q)
      && $stable(baStore_q) && aPortLinesOe == '0 && bPortLinesOe == '0)
    else $error("storage changed or port driven in isolation");
  direction_a: assert property (
    driveOk && !ctrl.outputEnableN |=> (aDrive_q == !$past(ctrl.direction))
      && (bDrive_q == $past(ctrl.direction)))
    else $error("wrong port driven for direction");
  a_live_a: assert property (
    driveOk && !ctrl.outputEnableN && !ctrl.direction && !ctrl.bToASourceSelect
      |=> aPortLinesOe == '1 && aPortLinesOut == $past(bLive))
    else $error("a port not following live b");
  a_stored_a: assert property (
    !ctrl.outputEnableN && !ctrl.direction && ctrl.bToASourceSelect
      |=> aPortLinesOut == $past(baStore_q))
    else $error("a port not showing b-to-a register");
  b_live_a: assert property (
    driveOk && !ctrl.outputEnableN && ctrl.direction && !ctrl.aToBSourceSelect
      |=> bPortLinesOe == '1 && bPortLinesOut == $past(aLive))
    else $error("b port not following live a");
  b_stored_a: assert property (
    !ctrl.outputEnableN && ctrl.direction && ctrl.aToBSourceSelect
      |=> bPortLinesOut == $past(abStore_q))
    else $error("b port not showing a-to-b register");
  input_capture_a: assert property (
    !ctrl.outputEnableN && ctrl.direction && abRise
      |=> bDrive_q && abStore_q == $past(aLive))
    else $error("undriven port capture lost in transceiver mode");
  no_contention_a: assert property (!(aDrive_q && bDrive_q))
    else $error("both ports driven");

  store_both_c: cover property (ctrl.outputEnableN && abRise && baRise);
  stored_to_a_c: cover property (aDrive_q && ctrl.bToASourceSelect ##1 baRise);
  log_full_c: cover property (!logReady ##1 popReady);
endmodule
`default_nettype wire

// ==== core/pin_sync.sv ====
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // pins and synchronised levels
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync WIDTH must be at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;
endmodule
`default_nettype wire

// ==== core/xcvr_fifo.sv ====
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module xcvr_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int unsigned PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PTR_W:0] count_q, count_d;
  logic push, pop;

  if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_chk
    $error("xcvr_fifo DEPTH must be a power of two, at least 2");
  end

  assign inReady = (count_q != (PTR_W + 1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_q];
  assign level = count_q;

  always_comb begin
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // storage needs no reset; pointers guard it
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule
`default_nettype wire

// ==== core/xcvr_pkg.sv ====
// shared constants and carriers for the octal registered bus transceiver
package xcvr_pkg;
  localparam int unsigned LANES = 8;
  localparam int unsigned LOG_DEPTH = 32;
  localparam int unsigned APB_ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] LOG_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] LOG_DATA_OFFSET = 8'h08;
  localparam logic [7:0] LOG_INFO_OFFSET = 8'h0C;

  // log control fields and reset value
  localparam int unsigned LOG_AB_EN_BIT = 0;
  localparam int unsigned LOG_BA_EN_BIT = 1;
  localparam logic [1:0] LOG_CTRL_RESET = 2'h3;

  // status fields
  localparam int unsigned STAT_AB_LSB = 0;
  localparam int unsigned STAT_BA_LSB = 8;
  localparam int unsigned STAT_A_DRIVE_BIT = 16;
  localparam int unsigned STAT_B_DRIVE_BIT = 17;
  localparam int unsigned STAT_CTRL_LSB = 18;

  // log data and log info fields
  localparam int unsigned LOGD_FROM_B_BIT = 8;
  localparam int unsigned LOGD_VALID_BIT = 31;
  localparam int unsigned LOGI_LEVEL_LSB = 0;
  localparam int unsigned LOGI_DROP_LSB = 8;
  localparam logic [7:0] DROP_RESET = 8'h00;

  // synchronised control pins, one bundle
  typedef struct packed {
    logic outputEnableN;
    logic direction;
    logic aToBSourceSelect;
    logic bToASourceSelect;
    logic aToBCaptureClock;
    logic bToACaptureClock;
  } pinCtrl_s;

  // one captured word as it enters the log
  typedef struct packed {
    logic fromB;
    logic [LANES-1:0] data;
  } logEntry_s;
endpackage

// ==== sim/bus_partner.sv ====
// far-side bus owner model for the a and b ports
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  // values the far side puts on each bus
  input wire logic [7:0] aHold,
  input wire logic [7:0] bHold,
  // transceiver drive per port
  input wire logic [7:0] aOut,
  input wire logic [7:0] aOe,
  input wire logic [7:0] bOut,
  input wire logic [7:0] bOe,
  // resolved bus levels
  output logic [7:0] aWire,
  output logic [7:0] bWire
);
  // owner yields every driven line, assumes nothing about the far port
  assign aWire = (aOe & aOut) | (~aOe & aHold);
  assign bWire = (bOe & bOut) | (~bOe & bHold);
endmodule
`default_nettype wire

// ==== sim/octal_registered_bus_transceiver_bench.sv ====
// self-checking bench for the octal registered bus transceiver
`timescale 1ns/1ps
`default_nettype none
module octal_registered_bus_transceiver_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, logReady, err;
  logic outputEnableN = 1'b1, direction = 1'b0, aToBSourceSelect = 1'b0;
  logic bToASourceSelect = 1'b0, aToBCaptureClock = 1'b0, bToACaptureClock = 1'b0;
  logic [7:0] aHold = 8'h00, bHold = 8'h00, aWire, bWire, aOut, aOe, bOut, bOe;
  logic dir, sel;
  int failCount = 0, nTests = 0;

  always #4 ref_clk = ~ref_clk;

  octal_registered_bus_transceiver u_octal_registered_bus_transceiver (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .outputEnableN(outputEnableN), .direction(direction),
    .aToBSourceSelect(aToBSourceSelect), .bToASourceSelect(bToASourceSelect),
    .aToBCaptureClock(aToBCaptureClock), .bToACaptureClock(bToACaptureClock),
    .aPortLinesIn(aWire), .aPortLinesOut(aOut), .aPortLinesOe(aOe),
    .bPortLinesIn(bWire), .bPortLinesOut(bOut), .bPortLinesOe(bOe), .logReady(logReady));

  bus_partner u_bus_partner (.aHold(aHold), .bHold(bHold), .aOut(aOut), .aOe(aOe),
    .bOut(bOut), .bOe(bOe), .aWire(aWire), .bWire(bWire));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      failCount++;
    end
  endtask

  task automatic endSim();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one apb transfer; waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdReg(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  // output path is two sync flops plus one output flop, twice over on live loops
  task automatic settle();
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic pins(input logic oeN, input logic d, input logic s);
    outputEnableN <= oeN;
    direction <= d;
    aToBSourceSelect <= s;
    bToASourceSelect <= s;
    settle();
  endtask

  // capture clocks held two cycles high so the sampler cannot miss them
  task automatic pulse(input logic ab, input logic ba);
    aToBCaptureClock <= ab;
    bToACaptureClock <= ba;
    repeat (2) @(posedge ref_clk);
    aToBCaptureClock <= 1'b0;
    bToACaptureClock <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    failCount++;
    endSim();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    settle();
    check("idle drive", {16'h0, aOe, bOe}, 32'h0000_0000);
    rdReg(xcvr_pkg::LOG_CTRL_OFFSET, 32'h0000_0003, "log ctrl");
    rdReg(xcvr_pkg::LOG_INFO_OFFSET, 32'h0000_0000, "log info");
    apb(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    $display("test reset done");
    aHold <= 8'hA5;
    bHold <= 8'h3C;
    settle();
    pulse(1'b0, 1'b1);
    rdReg(xcvr_pkg::LOG_DATA_OFFSET, 32'h8000_013C, "log from b");
    pulse(1'b1, 1'b0);
    rdReg(xcvr_pkg::LOG_DATA_OFFSET, 32'h8000_00A5, "log from a");
    rdReg(xcvr_pkg::STATUS_OFFSET, 32'h0080_3CA5, "isolated store");
    aHold <= 8'h00;
    bHold <= 8'hFF;
    settle();
    rdReg(xcvr_pkg::STATUS_OFFSET, 32'h0080_3CA5, "hold storage");
    check("isolated drive", {16'h0, aOe, bOe}, 32'h0000_0000);
    $display("test isolation done");
    aHold <= 8'h5A;
    bHold <= 8'hC3;
    for (int m = 0; m < 4; m++) begin
      dir = m[1];
      sel = m[0];
      pins(1'b0, dir, sel);
      check("a enable", {24'h0, aOe}, {24'h0, {8{~dir}}});
      check("b enable", {24'h0, bOe}, {24'h0, {8{dir}}});
      check("both driven", {24'h0, aOe & bOe}, 32'h0000_0000);
      check("drive data", {24'h0, dir ? bOut : aOut},
        {24'h0, dir ? (sel ? 8'hA5 : 8'h5A) : (sel ? 8'h3C : 8'hC3)});
      rdReg(xcvr_pkg::STATUS_OFFSET,
        {8'h0, 1'b0, dir, sel, sel, 2'b00, dir, ~dir, 8'h3C, 8'hA5}, "mode status");
    end
    $display("test modes done");
    pins(1'b0, 1'b1, 1'b0);
    aHold <= 8'h96;
    settle();
    pulse(1'b1, 1'b1);
    rdReg(xcvr_pkg::STATUS_OFFSET, 32'h0042_9696, "undriven capture");
    aHold <= 8'h00;
    pins(1'b0, 1'b1, 1'b1);
    check("stored to b", {24'h0, bOut}, 32'h0000_0096);
    $display("test transceiver capture done");
    pins(1'b1, 1'b0, 1'b0);
    apb(1'b1, xcvr_pkg::LOG_CTRL_OFFSET, 32'h0000_0001);
    // a write reads back zero, so prime the valid bit to enter the drain
    rd[31] = 1'b1;
    for (int i = 0; i < 40 && rd[31] !== 1'b0; i++) begin
      apb(1'b0, xcvr_pkg::LOG_DATA_OFFSET, 32'h0000_0000);
    end
    apb(1'b1, xcvr_pkg::LOG_INFO_OFFSET, 32'h0000_0000);
    rdReg(xcvr_pkg::LOG_INFO_OFFSET, 32'h0000_0000, "log emptied");
    // fill past the 32 entries so two captures are refused
    for (int i = 0; i < 34; i++) begin
      aHold <= 8'(i);
      repeat (2) @(posedge ref_clk);
      pulse(1'b1, 1'b0);
    end
    check("log full", {31'h0, logReady}, 32'h0000_0000);
    pulse(1'b0, 1'b1);
    rdReg(xcvr_pkg::LOG_INFO_OFFSET, 32'h0000_0220, "log level");
    for (int i = 0; i < 32; i++) begin
      rdReg(xcvr_pkg::LOG_DATA_OFFSET, 32'h8000_0000 | i, "log order");
    end
    rdReg(xcvr_pkg::LOG_DATA_OFFSET, 32'h0000_0000, "log drained");
    rdReg(xcvr_pkg::LOG_INFO_OFFSET, 32'h0000_0200, "drops kept");
    check("log ready", {31'h0, logReady}, 32'h0000_0001);
    apb(1'b1, xcvr_pkg::LOG_INFO_OFFSET, 32'h0000_0000);
    rdReg(xcvr_pkg::LOG_INFO_OFFSET, 32'h0000_0000, "drops cleared");
    $display("test log done");
    endSim();
  end
endmodule
`default_nettype wire
